/* src/pcm_enc_pkg.sv */
// Contract
// R1: Advance strobe passes one clock to start flop.
// R2: Control register fills ones, clears after delay.
// R3: Second stage fires selected converter start strobe.
// R4: Last stage fall samples select into enables.
// R5: Conversion done clears its converter enable.
// R6: Sample command high while sampling, then hold.
// R7: Start strobe sets code MSB as trial.
// R8: Code MSB is one for positive samples.
// R9: Later bits trialled, inverted when sign one.
// R10: Low comparator resets the trial bit.
// R11: Done flags, disables DAC, passes word on.
// R12: Odd and even converters alternate per channel.
// R13: Hold while converting, load, shift eight bits.
// R14: Advance sets self-clearing output pulse flop.
// R15: Pulse with select high loads odd serializer.
// R16: Select captured, slot-retimed, retimed for enables.
// R17: Enables release holds; even load gated pulse.
// R18: Low address selects input, next two decode.
// R19: Gated serializer outputs merge onto PCM out.
// R20: Select is the low channel address bit.
package pcm_enc_pkg;
  // Converter indices: select low picks the odd path.
  localparam int ODD = 0;
  localparam int EVEN = 1;
  // Clock rate and the settle delays before self clearing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLEAR_DELAY_NS = 10;
  localparam int CLEAR_DELAY_CYC = (CLEAR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_DELAY_NS = 20;
  localparam int PULSE_DELAY_CYC = (PULSE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clocks a trial code waits before its synchronised comparator reading is trusted.
  localparam int SAR_SETTLE_CYC = 3;
  // Control shift register length and code word width.
  localparam int CTRL_STAGES = 6;
  localparam int WORD_BITS = 8;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WORD_ODD_OFS = 8'h08;
  localparam logic [7:0] WORD_EVEN_OFS = 8'h0C;
  // Control register reset value: bit 0 runs the sequencer.
  localparam logic CTRL_RUN_RST = 1'b1;
  // Successive approximation state of one converter.
  typedef struct packed {
    logic busy;
    logic [2:0] idx;
    logic [7:0] code;
  } sar_t;
  // Parallel to serial state of one serializer.
  typedef struct packed {
    logic [7:0] shreg;
    logic [3:0] left;
  } ser_t;
endpackage

/* src/pcm_encoder_sequencer.sv */
`timescale 1ns/1ps
module pcm_encoder_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic channel_advance_strobe,
  input wire logic [4:0] channel_address,
  input wire logic slot_bit7_strobe,
  input wire logic slot_bit8_strobe,
  input wire logic [1:0] comparator_high,
  output logic [2:0] mux_input_select,
  output logic [2:0] mux_chip_select,
  output logic [1:0] sample_command,
  output logic [1:0] start_strobe_n,
  output logic [1:0] converter_enable,
  output logic [1:0] conversion_done,
  output logic [1:0] dac_disable,
  output logic [15:0] dac_code,
  output logic [1:0] shift_hold,
  output logic pcm_out
);

  // Two flop synchronisers for every pin input; stage one feeds only stage two.
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
    end else begin
      sync1_reg <= {comparator_high, slot_bit8_strobe, slot_bit7_strobe,
                    channel_address, channel_advance_strobe};
      sync2_reg <= sync1_reg;
    end
  end

  // Synchronised views of the pins.
  logic adv_s;
  logic [4:0] chan_s;
  logic slot_s;
  logic [1:0] comp_s;
  assign adv_s = sync2_reg[0];
  assign chan_s = sync2_reg[5:1];
  assign slot_s = sync2_reg[6] | sync2_reg[7];
  assign comp_s = sync2_reg[9:8];

  // Odd/even select is the low channel address bit, toggling each channel.
  logic odd_even_select;
  assign odd_even_select = chan_s[0]; // R20

  // Software controls: run gate for the advance strobe.
  logic run_reg;
  logic adv_d_reg;
  logic adv_rise;
  assign adv_rise = adv_s & ~adv_d_reg & run_reg;

  // Edge detector on the synchronised advance strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_d_reg <= 1'b0;
    end else begin
      adv_d_reg <= adv_s;
    end
  end

  // Start flop and control shift register with its clear delay.
  logic start_reg;
  logic [5:0] ctrl_sr_reg;
  logic [3:0] clr_cnt_reg;
  logic ctrl_clear;
  assign ctrl_clear = ctrl_sr_reg[5] && (clr_cnt_reg == 4'(pcm_enc_pkg::CLEAR_DELAY_CYC));

  // The start flop is set by one passed clock and released when the register clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
    end else if (adv_rise) begin
      start_reg <= 1'b1; // R1
    end else if (ctrl_clear) begin
      start_reg <= 1'b0;
    end
  end

  // Ones enter every clock while started; a short delay after the last stage clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sr_reg <= 6'h00;
      clr_cnt_reg <= 4'h0;
    end else if (!start_reg || ctrl_clear) begin
      ctrl_sr_reg <= 6'h00; // R2
      clr_cnt_reg <= 4'h0;
    end else begin
      ctrl_sr_reg <= {ctrl_sr_reg[4:0], 1'b1}; // R2
      if (ctrl_sr_reg[5]) begin
        clr_cnt_reg <= clr_cnt_reg + 4'h1;
      end
    end
  end

  // Stage edges that pace the sequence.
  logic stage2_rise;
  logic last_fall;
  logic last_d_reg;
  assign stage2_rise = ctrl_sr_reg[1] & ~ctrl_sr_reg[2] & start_reg;
  assign last_fall = last_d_reg & ~ctrl_sr_reg[5];

  // Remembers the last stage so its falling edge can be seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_d_reg <= 1'b0;
    end else begin
      last_d_reg <= ctrl_sr_reg[5];
    end
  end

  // Index of the converter chosen this channel.
  logic conv_sel;
  assign conv_sel = odd_even_select ? 1'b1 : 1'b0; // R12

  // Converter state per path.
  pcm_enc_pkg::sar_t sar_reg [2];
  logic [7:0] word_reg [2];
  logic [1:0] done_pulse;
  // Settle counters per path. The comparator answers through the DAC code register
  // and a two flop synchroniser, so a fresh trial is only visible some clocks later.
  // Trading speed for this wait keeps every bit judged against its own trial code.
  logic [1:0] settle_reg [2];

  // Start strobes go low for one clock; sample commands run from advance to start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_strobe_n <= 2'b11;
      sample_command <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        start_strobe_n[k] <= ~(stage2_rise && (conv_sel == k[0])); // R3
        sample_command[k] <= start_reg && !ctrl_sr_reg[1] && (conv_sel == k[0]); // R6
      end
    end
  end

  // Enables are loaded from the select at the last stage fall and ended by completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (last_fall) begin
          converter_enable[k] <= (k == pcm_enc_pkg::ODD) ? ~odd_even_select : odd_even_select; // R4
        end else if (done_pulse[k]) begin
          converter_enable[k] <= 1'b0; // R5
        end
      end
    end
  end

  // Resolve one trial bit: sign follows the comparator, later bits invert under a set sign.
  function automatic logic trial_result(input logic comp, input logic is_sign,
                                        input logic sign);
    if (is_sign) begin
      trial_result = comp; // R8
    end else if (!comp) begin
      trial_result = 1'b0; // R10
    end else begin
      trial_result = ~sign; // R9
    end
  endfunction

  // Successive approximation from the MSB down, one bit per settled comparator reading.
  // A new trial code takes one clock into the DAC code register and two more through
  // the comparator synchroniser, so each bit waits out that loop before it is judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 2; k++) begin
        sar_reg[k] <= '0;
        word_reg[k] <= 8'h00;
        settle_reg[k] <= 2'h0;
      end
      done_pulse <= 2'b00;
      dac_disable <= 2'b11;
    end else begin
      for (int k = 0; k < 2; k++) begin
        done_pulse[k] <= 1'b0;
        if (!start_strobe_n[k]) begin
          sar_reg[k].code <= 8'h80; // R7
          sar_reg[k].idx <= 3'd7;
          sar_reg[k].busy <= 1'b1;
          settle_reg[k] <= 2'h0;
          dac_disable[k] <= 1'b0;
        end else if (sar_reg[k].busy &&
                     settle_reg[k] != 2'(pcm_enc_pkg::SAR_SETTLE_CYC)) begin
          // The comparator still shows an older trial code; judging it now would be wrong.
          settle_reg[k] <= settle_reg[k] + 2'h1;
        end else if (sar_reg[k].busy) begin
          // The reading has settled: resolve this bit and restart the wait for the next.
          settle_reg[k] <= 2'h0;
          sar_reg[k].code[sar_reg[k].idx] <= trial_result(comp_s[k],
            sar_reg[k].idx == 3'd7, sar_reg[k].code[7]); // R9
          if (sar_reg[k].idx == 3'd0) begin
            sar_reg[k].busy <= 1'b0;
            done_pulse[k] <= 1'b1; // R11
            dac_disable[k] <= 1'b1; // R11
            word_reg[k] <= {sar_reg[k].code[7:1],
                            trial_result(comp_s[k], 1'b0, sar_reg[k].code[7])}; // R11
          end else begin
            sar_reg[k].idx <= sar_reg[k].idx - 3'd1;
            sar_reg[k].code[sar_reg[k].idx - 3'd1] <= 1'b1;
          end
        end
      end
    end
  end

  // Completion flags and the code presented to each DAC.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done <= 2'b00;
      dac_code <= 16'h0000;
    end else begin
      conversion_done <= done_pulse;
      dac_code <= {sar_reg[1].code, sar_reg[0].code};
    end
  end

  // Output pulse flop: set by each advance, self cleared after a short delay.
  logic out_pulse_reg;
  logic out_pulse_d_reg;
  logic [3:0] pulse_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pulse_reg <= 1'b0;
      pulse_cnt_reg <= 4'h0;
      out_pulse_d_reg <= 1'b0;
    end else begin
      out_pulse_d_reg <= out_pulse_reg;
      if (adv_rise) begin
        out_pulse_reg <= 1'b1; // R14
        pulse_cnt_reg <= 4'h0;
      end else if (out_pulse_reg) begin
        pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
        if (pulse_cnt_reg == 4'(pcm_enc_pkg::PULSE_DELAY_CYC - 1)) begin
          out_pulse_reg <= 1'b0; // R14
        end
      end
    end
  end

  // Select capture chain: pulse edge, slot strobe, then one more clock.
  logic cap_sel_reg;
  logic slot_sel_reg;
  logic out_sel_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sel_reg <= 1'b0;
      slot_sel_reg <= 1'b0;
      out_sel_reg <= 1'b0;
    end else begin
      if (out_pulse_reg && !out_pulse_d_reg) begin
        cap_sel_reg <= odd_even_select; // R16
      end
      if (slot_s) begin
        slot_sel_reg <= cap_sel_reg; // R16
      end
      out_sel_reg <= slot_sel_reg; // R16
    end
  end

  // Complementary output enables; odd follows a high select.
  logic [1:0] out_en;
  assign out_en = {~out_sel_reg, out_sel_reg};

  // Load strobes: odd on pulse with select high, even on pulse with even enable.
  logic [1:0] load;
  assign load[pcm_enc_pkg::ODD] = out_pulse_reg & ~out_pulse_d_reg & odd_even_select; // R15
  assign load[pcm_enc_pkg::EVEN] = out_pulse_reg & ~out_pulse_d_reg & out_en[1]; // R17

  // Serializers: held while converting or disabled, loaded, then eight shifts.
  pcm_enc_pkg::ser_t ser_reg [2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 2; k++) begin
        ser_reg[k] <= '0;
      end
      shift_hold <= 2'b11;
    end else begin
      for (int k = 0; k < 2; k++) begin
        shift_hold[k] <= sar_reg[k].busy | ~out_en[k] | load[k]; // R13 R17
        if (load[k]) begin
          ser_reg[k].shreg <= word_reg[k]; // R13
          ser_reg[k].left <= 4'(pcm_enc_pkg::WORD_BITS);
        end else if (!shift_hold[k] && ser_reg[k].left != 4'h0) begin
          ser_reg[k].shreg <= {ser_reg[k].shreg[6:0], 1'b0}; // R13
          ser_reg[k].left <= ser_reg[k].left - 4'h1;
        end
      end
    end
  end

  // Gated serializer outputs merged onto the PCM line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_out <= 1'b0;
    end else begin
      pcm_out <= (out_en[0] & ser_reg[0].shreg[7] & (ser_reg[0].left != 4'h0)) |
                 (out_en[1] & ser_reg[1].shreg[7] & (ser_reg[1].left != 4'h0)); // R19
    end
  end

  // Analog multiplexer addressing: low bits pick input, next two pick the chip.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_input_select <= 3'h0;
      mux_chip_select <= 3'h0;
    end else begin
      mux_input_select <= chan_s[2:0]; // R18
      unique case (chan_s[4:3])
        2'b00: mux_chip_select <= 3'b001; // R18
        2'b01: mux_chip_select <= 3'b010;
        2'b10: mux_chip_select <= 3'b100;
        2'b11: mux_chip_select <= 3'b000;
      endcase
    end
  end

  // APB slave: answers in the first access cycle, error on unmapped offsets.
  logic setup;
  logic mapped;
  assign setup = psel & ~penable;
  assign mapped = (paddr == pcm_enc_pkg::CTRL_OFS) || (paddr == pcm_enc_pkg::STATUS_OFS) ||
                  (paddr == pcm_enc_pkg::WORD_ODD_OFS) || (paddr == pcm_enc_pkg::WORD_EVEN_OFS);

  // Read mux and ready are registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      unique case (paddr)
        pcm_enc_pkg::CTRL_OFS: prdata <= {31'h0000_0000, run_reg};
        pcm_enc_pkg::STATUS_OFS: prdata <= {24'h00_0000, sar_reg[1].busy, sar_reg[0].busy,
                                            converter_enable, out_sel_reg, out_pulse_reg,
                                            ctrl_sr_reg[5], start_reg};
        pcm_enc_pkg::WORD_ODD_OFS: prdata <= {24'h00_0000, word_reg[0]};
        pcm_enc_pkg::WORD_EVEN_OFS: prdata <= {24'h00_0000, word_reg[1]};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // The run bit gates channel advances; written only at the completing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= pcm_enc_pkg::CTRL_RUN_RST;
    end else if (psel && penable && pready && pwrite && paddr == pcm_enc_pkg::CTRL_OFS) begin
      run_reg <= pwdata[0];
    end
  end

endmodule

/* verification/pcm_enc_analog_model.sv */
`timescale 1ns/1ps
// Held samples and comparators of both converter paths.
module pcm_enc_analog_model (
  input wire logic [15:0] level,
  input wire logic [15:0] dac_code,
  output logic [1:0] comparator_high
);
  // High while the held level is at or above the trial code.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      comparator_high[i] = dac_code[i*8 +: 8] <= level[i*8 +: 8];
    end
  end
endmodule

/* verification/pcm_enc_assertions.sv */
`timescale 1ns/1ps
// Watches the sequencing and channel select outputs of the encoder.
module pcm_enc_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] channel_address,
  input wire logic [2:0] mux_input_select,
  input wire logic [2:0] mux_chip_select,
  input wire logic [1:0] start_strobe_n,
  input wire logic [1:0] converter_enable,
  input wire logic [1:0] conversion_done,
  input wire logic [1:0] dac_disable,
  input wire logic [15:0] dac_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since reset; the pin synchronisers need time to fill.
  logic [2:0] up_cnt_reg;
  // Count saturates so it never wraps back into the blind window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt_reg <= 3'h0;
    end else if (up_cnt_reg != 3'h7) begin
      up_cnt_reg <= up_cnt_reg + 3'h1;
    end
  end
  // The channel number has held still long enough to cross the synchronisers.
  sequence addr_settled;
    $stable(channel_address) [*4] ##0 (up_cnt_reg == 3'h7);
  endsequence
  AST_ONE_STROBE: assert property (start_strobe_n != 2'h0)
    else $error("both converter start strobes low");
  AST_STROBE_PULSE: assert property (start_strobe_n != 2'h3 |=> start_strobe_n == 2'h3)
    else $error("start strobe longer than one cycle");
  AST_MSB_TRIAL: assert property ($fell(start_strobe_n[0]) |-> ##[0:2] dac_code[7])
    else $error("odd code top bit not tried after start");
  AST_DONE_PULSE: assert property (conversion_done != 2'h0 |=> conversion_done == 2'h0)
    else $error("conversion done longer than one cycle");
  AST_DONE_ENABLE: assert property (conversion_done[0] |-> ##[0:1] !converter_enable[0])
    else $error("odd enable not cleared by done");
  AST_DONE_DAC: assert property (conversion_done[1] |-> ##[0:1] dac_disable[1])
    else $error("even converter not disabled by done");
  AST_CHIP_ONEHOT: assert property ($onehot0(mux_chip_select))
    else $error("several chip selects active");
  AST_MUX_ADDR: assert property (addr_settled |-> mux_input_select == channel_address[2:0])
    else $error("input select differs from channel number");
  AST_CHIP_DECODE: assert property (addr_settled |-> mux_chip_select ==
    (channel_address[4:3] == 2'h3 ? 3'h0 : 3'h1 << channel_address[4:3]))
    else $error("chip select decode wrong");
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  AST_APB_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind pcm_encoder_sequencer pcm_enc_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .channel_address(channel_address),
  .mux_input_select(mux_input_select), .mux_chip_select(mux_chip_select),
  .start_strobe_n(start_strobe_n), .converter_enable(converter_enable),
  .conversion_done(conversion_done), .dac_disable(dac_disable), .dac_code(dac_code)
);

/* verification/pcm_encoder_sequencer_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the encoder sequencer.
module pcm_encoder_sequencer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic adv = 1'b0;
  logic [4:0] chan = 5'h00;
  logic s7 = 1'b0;
  logic s8 = 1'b0;
  logic [15:0] level = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, pcm_out;
  logic [1:0] comp, sample_command, start_strobe_n, converter_enable;
  logic [1:0] conversion_done, dac_disable, shift_hold;
  logic [2:0] mux_input_select, mux_chip_select;
  logic [15:0] dac_code;
  int mismatches = 0;
  int n_tests = 0;
  int slot_cnt = 0;
  // Last odd word converted; the odd serializer sends it during the next even channel.
  logic [7:0] prev_odd = 8'h00;
  pcm_encoder_sequencer i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_advance_strobe(adv), .channel_address(chan), .slot_bit7_strobe(s7),
    .slot_bit8_strobe(s8), .comparator_high(comp), .mux_input_select(mux_input_select),
    .mux_chip_select(mux_chip_select), .sample_command(sample_command),
    .start_strobe_n(start_strobe_n), .converter_enable(converter_enable),
    .conversion_done(conversion_done), .dac_disable(dac_disable), .dac_code(dac_code),
    .shift_hold(shift_hold), .pcm_out(pcm_out)
  );
  pcm_enc_analog_model i_model (.level(level), .dac_code(dac_code), .comparator_high(comp));
  // Clock of 5 ns period.
  always #2.5 pclk = !pclk;
  // Slot strobes every eight clocks, bit 8 one clock after bit 7.
  always @(posedge pclk) begin
    slot_cnt <= (slot_cnt + 1) % 8;
    s7 <= (slot_cnt == 6);
    s8 <= (slot_cnt == 7);
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A wait that ran out is a failure in itself.
  task automatic hang();
    mismatches++;
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the idle cycle first keeps back-to-back calls clean.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) hang();
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic advance();
    adv <= 1'b1;
    repeat (3) @(posedge pclk);
    adv <= 1'b0;
  endtask
  // Reset value, an unmapped place, and advances ignored while stopped.
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    int i;
    apb(1'b0, pcm_enc_pkg::CTRL_OFS, 32'h0, r, e);
    chk(r, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    chk(e, 32'h0000_0001);
    apb(1'b1, pcm_enc_pkg::CTRL_OFS, 32'h0, r, e);
    advance();
    for (i = 0; i < 40 && start_strobe_n === 2'h3; i++) @(posedge pclk);
    chk(i, 40);
    apb(1'b1, pcm_enc_pkg::CTRL_OFS, 32'h0000_0001, r, e);
    $display("test registers done");
  endtask
  // Every channel number reaches the input and chip selects.
  task automatic t_mux();
    for (int a = 0; a < 32; a++) begin
      chan <= a[4:0];
      repeat (4) @(posedge pclk);
      chk(mux_input_select, a[2:0]);
      chk(mux_chip_select, a[4:3] == 2'h3 ? 3'h0 : 3'h1 << a[4:3]);
    end
    $display("test channel select done");
  endtask
  // One channel converted on the path that its low address bit picks.
  task automatic t_conv(input logic sel, input logic [7:0] lvl);
    int k;
    int i;
    logic [7:0] exp;
    logic [31:0] r;
    logic e;
    logic [7:0] bits;
    int n_samp;
    k = sel ? pcm_enc_pkg::EVEN : pcm_enc_pkg::ODD;
    exp = lvl[7] ? 8'h80 : lvl;
    chan <= {4'h0, sel};
    level[k*8 +: 8] <= lvl;
    repeat (4) @(posedge pclk);
    advance();
    n_samp = 0;
    for (i = 0; i < 20 && start_strobe_n === 2'h3; i++) begin
      if (sample_command[k] === 1'b1) n_samp++;
      @(posedge pclk);
    end
    if (i == 20) hang();
    chk(start_strobe_n, sel ? 2'h1 : 2'h2);
    chk(n_samp != 0, 1'b1);
    chk(sample_command, 2'h0);
    // During an even channel the odd serializer sends the previous odd word, MSB first.
    if (sel) begin
      for (i = 0; i < 20 && shift_hold[0] !== 1'b0; i++) @(posedge pclk);
      if (i == 20) hang();
      for (int j = 0; j < 8; j++) begin
        @(posedge pclk);
        bits = {bits[6:0], pcm_out};
      end
      chk(bits, prev_odd);
    end
    repeat (8) @(posedge pclk);
    chk(converter_enable, sel ? 2'h2 : 2'h1);
    for (i = 0; i < 40 && conversion_done[k] !== 1'b1; i++) @(posedge pclk);
    if (i == 40) hang();
    chk(dac_code[k*8 +: 8], exp);
    repeat (2) @(posedge pclk);
    chk(dac_disable[k], 1'b1);
    chk(converter_enable[k], 1'b0);
    apb(1'b0, sel ? pcm_enc_pkg::WORD_EVEN_OFS : pcm_enc_pkg::WORD_ODD_OFS, 32'h0, r, e);
    chk(r, {24'h0, exp});
    if (!sel) prev_odd = exp;
    $display("test conversion done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mux();
    t_conv(1'b0, 8'h5A);
    t_conv(1'b1, 8'h93);
    t_conv(1'b0, 8'h00);
    t_conv(1'b1, 8'h7F);
    stop_test();
  end
endmodule
